// File: psled_phy_status_led_driver.sv
/*
 PHY status indicator driver: duplex/collision, speed and link/activity
 outputs, all active low. Assumes PHY status from another clock domain and
 board LEDs lit by a low level.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psled_map.svh"

module psled_phy_status_led_driver #(
   parameter int unsigned PHASE_CYC = `PSLED_PHASE_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // PHY status, asynchronous
   input wire psled_pkg::psled_phy_status_t phyStatus,
   // Power-on setting straps, asynchronous
   input wire logic [1:0] strapIn,
   // Captured straps
   output logic [1:0] strapValue,
   // Indicators, active low
   output logic duplex_led_n,
   output logic speed_led_n,
   output logic link_activity_led_n
);
   import psled_pkg::*;

   initial begin
      if (PHASE_CYC < 2) $error("PHASE_CYC too small");
   end

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   psled_phy_status_t syncA;
   psled_phy_status_t syncB;
   logic [1:0] strapA;
   logic [1:0] strapB;
   logic strapTaken;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= '0;
         syncB <= '0;
         strapA <= 2'h0;
         strapB <= 2'h0;
      end else begin
         syncA <= phyStatus;
         syncB <= syncA;
         strapA <= strapIn;
         strapB <= strapA;
      end
   end

   // ----------------------------------------
   // Strap capture after reset release
   // ----------------------------------------
   // Taken once the synchroniser has filled, so the value is clean
   logic [1:0] strapCnt;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strapCnt <= 2'h0;
         strapTaken <= 1'b0;
         strapValue <= 2'h0;
      end else if (!strapTaken) begin
         strapCnt <= strapCnt + 2'h1;
         if (strapCnt == 2'h2) begin
            strapTaken <= 1'b1;
            strapValue <= strapB;
         end
      end
   end

   // ----------------------------------------
   // Collision and activity edges
   // ----------------------------------------
   logic colPrev;
   logic actPrev;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         colPrev <= 1'b0;
         actPrev <= 1'b0;
      end else begin
         colPrev <= syncB.collision;
         actPrev <= syncB.activity;
      end
   end

   wire logic colEvent = syncB.collision & ~colPrev;
   wire logic actEvent = syncB.activity & ~actPrev;
   wire logic halfLink = syncB.linkUp & ~syncB.fullDuplex;
   wire logic colBlink;
   wire logic actBlink;

   psled_blinker #(
      .PHASE_CYC(PHASE_CYC)
   ) u_col_blink (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .enable(halfLink),
      .trigger(colEvent),
      .pulseOn(colBlink)
   );

   psled_blinker #(
      .PHASE_CYC(PHASE_CYC)
   ) u_act_blink (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .enable(syncB.linkUp),
      .trigger(actEvent),
      .pulseOn(actBlink)
   );

   // ----------------------------------------
   // Indicator levels
   // ----------------------------------------
   // Collision pulse drives low; a full duplex link also lights the LED
   wire logic next_duplex = ~((syncB.linkUp & syncB.fullDuplex) | colBlink);
   wire logic next_speed = ~(syncB.linkUp & syncB.speed100);
   wire logic next_link = ~syncB.linkUp | actBlink;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         duplex_led_n <= `PSLED_LED_OFF;
         speed_led_n <= `PSLED_LED_OFF;
         link_activity_led_n <= `PSLED_LED_OFF;
      end else begin
         duplex_led_n <= next_duplex;
         speed_led_n <= next_speed;
         link_activity_led_n <= next_link;
      end
   end

endmodule : psled_phy_status_led_driver

`default_nettype wire

// File: psled_map.svh
/*
 Constants for the PHY status indicator driver: blink timing and reset levels.
 Assumes inclusion by the top module and the blinker; definitions only.
*/
`ifndef PSLED_MAP_SVH
`define PSLED_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSLED_CLK_HZ 50000000
`define PSLED_PHASE_MS 80
`define PSLED_PHASE_CYC ((`PSLED_CLK_HZ / 1000) * `PSLED_PHASE_MS)

// ----------------------------------------
// Reset levels of the indicators (LED off)
// ----------------------------------------
`define PSLED_LED_OFF 1'b1

`endif

// File: psled_pkg.sv
/*
 Types for the PHY status indicator driver.
 Assumes compilation before the design modules.
*/
package psled_pkg;

   // ----------------------------------------
   // PHY status carrier
   // ----------------------------------------
   typedef struct packed {
      logic linkUp;
      logic fullDuplex;
      logic speed100;
      logic collision;
      logic activity;
   } psled_phy_status_t;

   typedef enum logic [1:0] {
      PSLED_IDLE,
      PSLED_PULSE,
      PSLED_GAP
   } psled_blink_state_t;

endpackage : psled_pkg

// File: psled_blinker.sv
/*
 One blink sequencer: an event starts a pulse phase, then a guard phase, each
 PHASE_CYC cycles long. Assumes a synchronous trigger on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psled_map.svh"

module psled_blinker #(
   parameter int unsigned PHASE_CYC = `PSLED_PHASE_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Control
   input wire logic enable,
   input wire logic trigger,
   // Status
   output logic pulseOn
);
   import psled_pkg::*;

   localparam int CW = $clog2(PHASE_CYC + 1);

   initial begin
      if (PHASE_CYC < 1) $error("PHASE_CYC must be at least 1");
   end

   psled_blink_state_t state;
   psled_blink_state_t next_state;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   wire logic phaseDone = (count == CW'(PHASE_CYC - 1));

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_count = count + CW'(1);
      case (state)
         PSLED_IDLE: begin
            next_count = '0;
            if (enable && trigger) begin
               next_state = PSLED_PULSE;
            end
         end
         PSLED_PULSE: begin
            if (phaseDone) begin
               next_state = PSLED_GAP;
               next_count = '0;
            end
         end
         PSLED_GAP: begin
            // Events in the guard phase are dropped, not queued
            if (phaseDone) begin
               next_state = PSLED_IDLE;
               next_count = '0;
            end
         end
         default: begin
            next_state = PSLED_IDLE;
            next_count = '0;
         end
      endcase
      // Losing the mode aborts any blink at once
      if (!enable) begin
         next_state = PSLED_IDLE;
         next_count = '0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PSLED_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign pulseOn = (state == PSLED_PULSE);

endmodule : psled_blinker

`default_nettype wire

// File: psled_led_model.sv
/* Board indicators: a lamp is lit while its pin is low.
 Assumes the driver's pins connect straight to the lamps. */
`timescale 1ns/1ps
`default_nettype none
module psled_led_model (
   // Indicator pins
   input wire logic duplex_led_n,
   input wire logic speed_led_n,
   input wire logic link_activity_led_n,
   // Lamp states
   output logic [2:0] lit
);
   assign lit = ~{duplex_led_n, speed_led_n, link_activity_led_n};
endmodule : psled_led_model
`default_nettype wire

// File: psled_phy_status_led_driver_sva.sv
/* Port checker for the status indicator driver.
 Assumes it is bound with the instance's own PHASE_CYC. */
`timescale 1ns/1ps
`default_nettype none
module psled_phy_status_led_driver_sva
   import psled_pkg::*;
#(
   parameter int unsigned PHASE_CYC = 4000000
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Inputs
   input wire psled_phy_status_t phyStatus,
   input wire logic [1:0] strapIn,
   // Outputs
   input wire logic [1:0] strapValue,
   input wire logic duplex_led_n,
   input wire logic speed_led_n,
   input wire logic link_activity_led_n
);
   int unsigned runLen;
   int unsigned linkLen;
   // Edges since reset release; covers a reset that falls inside a check window
   int unsigned upCnt;
   logic lastLed;
   wire logic lk = phyStatus.linkUp;
   wire logic hd = phyStatus.linkUp && !phyStatus.fullDuplex;
   // Run length of the activity pin, read at each change
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         runLen <= 0;
         linkLen <= 0;
         upCnt <= 0;
         lastLed <= 1'b1;
      end else begin
         lastLed <= link_activity_led_n;
         runLen <= (link_activity_led_n != lastLed) ? 1 : runLen + 1;
         linkLen <= !lk ? 0 : ((linkLen < 1000) ? linkLen + 1 : linkLen);
         upCnt <= (upCnt < 1000) ? upCnt + 1 : upCnt;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   speed_fast_a: assert property (
      upCnt >= 3 && $past(lk && phyStatus.speed100, 3) |-> !speed_led_n) else $error("speed");
   speed_slow_a: assert property (
      upCnt >= 3 && $past(lk && !phyStatus.speed100, 3) |-> speed_led_n) else $error("speed");
   full_dup_a: assert property (
      upCnt >= 3 && $past(lk && !hd, 3) |-> !duplex_led_n) else $error("duplex");
   link_down_a: assert property (
      upCnt >= 3 && $past(!lk, 3) |-> link_activity_led_n) else $error("link");
   col_start_a: assert property (
      $fell(duplex_led_n) && upCnt >= 5 && $past(hd, 3) && $past(hd, 4)
      |-> $past(phyStatus.collision, 4) && !$past(phyStatus.collision, 5)) else $error("col");
   act_start_a: assert property (
      $rose(link_activity_led_n) && upCnt >= 5 && $past(lk, 3)
      |-> $past(phyStatus.activity, 4) && !$past(phyStatus.activity, 5)) else $error("act");
   pulse_len_a: assert property (
      $fell(link_activity_led_n) && linkLen > PHASE_CYC + 4 |-> runLen == PHASE_CYC)
      else $error("pulse length");
   act_gap_a: assert property (
      $rose(link_activity_led_n) && linkLen > 3 * PHASE_CYC |-> runLen >= PHASE_CYC)
      else $error("gap");
   strap_hold_a: assert property (
      upCnt >= 4 |-> $stable(strapValue)) else $error("strap");
endmodule : psled_phy_status_led_driver_sva
bind psled_phy_status_led_driver psled_phy_status_led_driver_sva #(.PHASE_CYC(PHASE_CYC)) chk_i (
   .core_clk(core_clk), .rst_n(rst_n), .phyStatus(phyStatus), .strapIn(strapIn),
   .strapValue(strapValue), .duplex_led_n(duplex_led_n), .speed_led_n(speed_led_n),
   .link_activity_led_n(link_activity_led_n));
`default_nettype wire

// File: psled_phy_status_led_driver_tb.sv
/* Bench for the status indicator driver, phases shortened to 8 cycles.
 Assumes design, lamp model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module psled_phy_status_led_driver_tb;
   import psled_pkg::*;
   localparam int unsigned P = 8;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   psled_phy_status_t st = '0;
   logic [1:0] strapIn = 2'h2;
   logic [1:0] strapValue;
   logic duplexLedN, speedLedN, actLedN;
   logic [2:0] lit;
   int fails = 0;
   int n_tests = 0;
   int n;
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   psled_phy_status_led_driver #(.PHASE_CYC(P)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .phyStatus(st), .strapIn(strapIn), .strapValue(strapValue), .duplex_led_n(duplexLedN),
      .speed_led_n(speedLedN), .link_activity_led_n(actLedN));
   psled_led_model LEDS (.duplex_led_n(duplexLedN), .speed_led_n(speedLedN),
      .link_activity_led_n(actLedN), .lit(lit));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : cyc
   // One-cycle event on collision (0) or activity (1)
   task ev(input bit s);
      if (s) st.activity = 1'b1; else st.collision = 1'b1;
      cyc(1);
      st.activity = 1'b0;
      st.collision = 1'b0;
   endtask : ev
   // Waits for level v on a pin, then counts its cycles, capped at 40
   task run_len(input bit s, input logic v, output int len);
      len = 0;
      for (int i = 0; i < 20 && (s ? actLedN : duplexLedN) !== v; i++) cyc(1);
      while ((s ? actLedN : duplexLedN) === v && len < 40) begin
         cyc(1);
         len++;
      end
   endtask : run_len
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_levels;
      for (int m = 0; m < 8; m++) begin
         st = {m[2:0], 2'b00};
         cyc(5);
         chk(lit, {m[2] && m[1], m[2] && m[0], m[2]});
      end
   endtask : t_levels
   task t_blink(input bit s);
      st = s ? 5'b11000 : 5'b10000;
      cyc(5);
      ev(s);
      run_len(s, s, n);
      chk(n, P);
      ev(s);
      run_len(s, !s, n);
      chk(n, 40);
      ev(s);
      run_len(s, s, n);
      chk(n, P);
   endtask : t_blink
   task close_out;
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   initial begin
      cyc(3);
      chk({duplexLedN, speedLedN, actLedN, strapValue}, 8'h1c);
      cyc(9);
      rst_n = 1'b1;
      cyc(6);
      chk(strapValue, 2'h2);
      t_levels;
      t_blink(1'b1);
      t_blink(1'b0);
      rst_n = 1'b0;
      strapIn = 2'h1;
      cyc(1);
      chk({duplexLedN, speedLedN, actLedN, strapValue}, 8'h1c);
      rst_n = 1'b1;
      cyc(6);
      chk(strapValue, 2'h1);
      close_out;
   end
   initial begin
      #50000;
      fails++;
      close_out;
   end
endmodule : psled_phy_status_led_driver_tb
`default_nettype wire
